// ===== verilog/power_loss_decel_defines.svh
// Purpose: named constants for the power-loss controlled deceleration block
// Assumes: voltages in 0.1 V units, frequency in 0.01 Hz, time in 0.01 s
// Notes: definitions only
`ifndef POWER_LOSS_DECEL_DEFINES_SVH
`define POWER_LOSS_DECEL_DEFINES_SVH

// enable setting codes
`define PLD_CODE_DISABLE 2'h0
`define PLD_CODE_ENABLE 2'h1
// setting limits (0.1 V, 0.01 Hz, 0.01 s units)
`define PLD_VOLT_MAX 14'h2710
`define PLD_STEP_MAX 10'h3e8
`define PLD_TIME_MIN 19'h00001
`define PLD_TIME_MAX 19'h57e40
// one time unit of the decel setting, in ns (0.01 s)
`define PLD_TIME_UNIT_NS 32'h00989680
// clock period in ns
`define PLD_CLK_PERIOD_NS 32'h00000008
// ticks per time unit, derived from the clock rate
`define PLD_TICKS_PER_UNIT (`PLD_TIME_UNIT_NS / `PLD_CLK_PERIOD_NS)
`define PLD_FREQ_ZERO 16'h0000
// time base counter start and step
`define PLD_CNT_ZERO 32'h00000000
`define PLD_CNT_ONE 32'h00000001
// reset values of the slope and the status flags
`define PLD_RATE_RESET 16'h0000
`define PLD_FLAG_SET 1'h1
`define PLD_FLAG_CLEAR 1'h0

`endif

// ===== verilog/power_loss_decel_pkg.sv
// Purpose: types for the power-loss controlled deceleration block
// Assumes: nothing beyond the defines header
// Notes: settings travel as one packed struct
package power_loss_decel_pkg;

  // operating state of the ride-through logic
  typedef enum logic [2:0] {
    ST_RUN,
    ST_COAST,
    ST_STEP,
    ST_RAMP,
    ST_HOLD,
    ST_DONE
  } pld_state_t;

  // configuration bundle
  typedef struct packed {
    logic [1:0] power_loss_decel_enable;
    logic [13:0] bus_trigger_level;
    logic [13:0] bus_overvoltage_threshold;
    logic [18:0] power_loss_decel_time;
    logic [9:0] initial_freq_step_drop;
  } pld_cfg_t;

endpackage : power_loss_decel_pkg

// ===== verilog/power_loss_decel.sv
// Purpose: ride-through controlled stop of the drive on loss of input power
//   stepping the frequency down, then ramping it to zero
// Assumes: bus voltage sampled every clock, settings held stable
//   under-voltage is detected outside and arrives as a level
// Notes: ramp slope is fixed at the step drop from frequency and decel time
//   over-voltage threshold must sit above the trigger level
//   status flags are registered with the state they report
`timescale 1ns/10ps
`default_nettype none
`include "power_loss_decel_defines.svh"

module power_loss_decel (
  input wire logic ref_clk_in, // control clock, 125 MHz
  input wire logic resetn_in, // synchronous reset, active low
  input wire power_loss_decel_pkg::pld_cfg_t cfg_in, // settings
  input wire logic input_power_ok_in, // mains present
  input wire logic [13:0] bus_voltage_in, // dc bus, 0.1 V units
  input wire logic under_voltage_in, // bus energy depleted
  input wire logic [15:0] freq_ref_in, // normal output freq, 0.01 Hz
  output logic [15:0] freq_out, // commanded output freq
  output logic output_enable_out, // inverter output active
  output logic decel_active_out, // controlled decel in progress
  output logic hold_out // ramp paused on over-voltage
);
  import power_loss_decel_pkg::*;

  localparam logic [31:0] TICKS = `PLD_TICKS_PER_UNIT;
  // a time unit spans TICKS clocks, so one ramp decrement takes
  // over a million clocks; short runs only see the step and pauses

  // ride-through state, output frequency and the slope fixed at loss
  pld_state_t state, next_state;
  logic [15:0] freq, next_freq;
  logic [15:0] rate, next_rate; // 0.01 hz removed per time unit
  // status flags, registered so they change with the state they report
  logic output_enable, next_output_enable;
  logic decel_active, next_decel_active;
  logic hold, next_hold;
  // time base of the ramp, one unit is 0.01 s worth of clocks
  logic [31:0] sub_cnt, next_sub_cnt;
  logic unit_tick; // last clock of a time unit
  logic ramp_run; // ramp allowed to advance this clock

  // enable decode, used once to form feature_enabled
  function automatic logic feature_on(input logic [1:0] code);
    feature_on = (code == `PLD_CODE_ENABLE);
  endfunction : feature_on

  // states in which the controlled stop is under way
  function automatic logic in_decel(input pld_state_t st);
    in_decel = (st == ST_STEP) || (st == ST_RAMP) || (st == ST_HOLD);
  endfunction : in_decel

  // states in which the inverter output stays switched on
  function automatic logic output_live(input pld_state_t st);
    output_live = (st != ST_COAST) && (st != ST_DONE);
  endfunction : output_live

  logic at_trigger, over_volt, feature_enabled;
  logic [18:0] dtime;
  logic [15:0] step_ext, stepped_freq, rate_calc, ramped_freq;

  // threshold compares, evaluated every tick
  assign at_trigger = bus_voltage_in <= cfg_in.bus_trigger_level;
  assign over_volt = bus_voltage_in >
                     cfg_in.bus_overvoltage_threshold;
  assign feature_enabled = feature_on(cfg_in.power_loss_decel_enable);
  // a zero decel time would divide by zero, so it counts as one unit
  assign dtime = (cfg_in.power_loss_decel_time < `PLD_TIME_MIN) ?
                 `PLD_TIME_MIN : cfg_in.power_loss_decel_time;

  // step and slope arithmetic, both floored at zero frequency
  assign step_ext = 16'(cfg_in.initial_freq_step_drop);
  assign stepped_freq = (freq > step_ext) ? freq - step_ext :
                        `PLD_FREQ_ZERO;
  // ceiling division: full reference reaches zero within the decel time
  // the divider is wide, but its result is only kept at the step
  assign rate_calc = 16'((32'(freq_ref_in) + 32'(dtime) - `PLD_CNT_ONE) /
                         32'(dtime));
  assign ramped_freq = (freq > rate) ? freq - rate : `PLD_FREQ_ZERO;

  // the ramp advances only in ramp state with no stop or pause pending
  assign ramp_run = (state == ST_RAMP) && !under_voltage_in &&
                    (freq != `PLD_FREQ_ZERO) && !over_volt;

  // time base: restarts at the step, counts while the ramp advances,
  // and keeps its count across a pause so no partial unit is lost
  always_comb begin
    next_sub_cnt = sub_cnt;
    unit_tick = 1'h0;
    if (state == ST_STEP) begin
      next_sub_cnt = `PLD_CNT_ZERO;
    end else if (ramp_run) begin
      if (sub_cnt == TICKS - `PLD_CNT_ONE) begin
        next_sub_cnt = `PLD_CNT_ZERO;
        unit_tick = 1'h1;
      end else begin
        next_sub_cnt = sub_cnt + `PLD_CNT_ONE;
      end
    end
  end

  // time base register
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      sub_cnt <= `PLD_CNT_ZERO;
    end else begin
      sub_cnt <= next_sub_cnt;
    end
  end

  // next state, output frequency, slope and status flags
  // state, frequency and slope default to their registers and the flags are always set, so nothing is left undriven
  always_comb begin
    next_state = state;
    next_freq = freq;
    next_rate = rate;
    case (state)
      ST_RUN: begin
        // normal running: frequency follows the reference
        next_freq = freq_ref_in;
        if (!input_power_ok_in) begin
          // mains lost above the trigger with the feature enabled: keep running on bus energy
          if (feature_enabled && at_trigger) begin
            next_state = ST_STEP;
          end else if (!feature_enabled) begin
            next_state = ST_COAST;
            next_freq = `PLD_FREQ_ZERO;
          end
        end
      end

      ST_COAST: begin
        // output removed, motor coasts; no ramp is attempted
        next_freq = `PLD_FREQ_ZERO;
        if (input_power_ok_in) begin
          next_state = ST_RUN;
        end
      end

      ST_STEP: begin
        // initial step drop, then fix the linear slope for the whole stop
        next_freq = stepped_freq;
        next_rate = rate_calc;
        next_state = ST_RAMP;
      end

      ST_RAMP: begin
        // power return is ignored here: the stop always completes
        if (under_voltage_in || freq == `PLD_FREQ_ZERO) begin
          next_state = ST_DONE;
          next_freq = `PLD_FREQ_ZERO;
        end else if (over_volt) begin
          next_state = ST_HOLD;
        end else if (unit_tick) begin
          next_freq = ramped_freq;
        end
      end

      ST_HOLD: begin
        // freq held constant; power return does not abort
        if (under_voltage_in) begin
          next_state = ST_DONE;
          next_freq = `PLD_FREQ_ZERO;
        end else if (!over_volt) begin
          next_state = ST_RAMP;
        end
      end

      ST_DONE: begin
        // stopped; run mode comes back by itself once mains is good and under-voltage is gone
        next_freq = `PLD_FREQ_ZERO;
        if (input_power_ok_in && !under_voltage_in) begin
          next_state = ST_RUN;
        end
      end

      default: begin
        next_state = ST_RUN;
      end
    endcase
    // flags follow the state being entered, so they change with it
    next_output_enable = output_live(next_state);
    next_decel_active = in_decel(next_state);
    next_hold = (next_state == ST_HOLD);
  end

  // state registers
  // reset leaves the drive in run mode with its output switched on
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      state <= ST_RUN;
      freq <= `PLD_FREQ_ZERO;
      rate <= `PLD_RATE_RESET;
      output_enable <= `PLD_FLAG_SET;
      decel_active <= `PLD_FLAG_CLEAR;
      hold <= `PLD_FLAG_CLEAR;
    end else begin
      state <= next_state;
      freq <= next_freq;
      rate <= next_rate;
      output_enable <= next_output_enable;
      decel_active <= next_decel_active;
      hold <= next_hold;
    end
  end

  // outputs straight from the registers
  assign freq_out = freq;
  assign output_enable_out = output_enable;
  assign decel_active_out = decel_active;
  assign hold_out = hold;

endmodule : power_loss_decel
`default_nettype wire

// ===== testbench/power_loss_decel_chk.sv
// Purpose: assertion checker for power_loss_decel
// Assumes: sees only the top module ports
// Notes: bound at the foot of this file
`timescale 1ns/10ps
`default_nettype none
module power_loss_decel_chk (
  input wire logic ref_clk_in, resetn_in, input_power_ok_in, under_voltage_in,
  input wire power_loss_decel_pkg::pld_cfg_t cfg_in,
  input wire logic [13:0] bus_voltage_in,
  input wire logic [15:0] freq_out,
  input wire logic output_enable_out, decel_active_out, hold_out
);
  import power_loss_decel_pkg::*;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!resetn_in);
  // running normally, and decel under way with no under-voltage
  wire logic idle = output_enable_out && !decel_active_out;
  wire logic ramp = decel_active_out && !under_voltage_in;
  a_coast_stop: assert property (idle && !input_power_ok_in &&
    cfg_in.power_loss_decel_enable == 2'h0 |=>
    !output_enable_out && freq_out == 16'h0000) else $error("no coast");
  a_decel_start: assert property (idle && !input_power_ok_in &&
    cfg_in.power_loss_decel_enable == 2'h1 &&
    bus_voltage_in <= cfg_in.bus_trigger_level |=> decel_active_out)
    else $error("no decel start");
  a_step_drop: assert property ($rose(decel_active_out) &&
    freq_out >= {6'h00, cfg_in.initial_freq_step_drop} |=> freq_out ==
    $past(freq_out) - {6'h00, cfg_in.initial_freq_step_drop})
    else $error("bad step");
  a_hold_still: assert property (hold_out |=>
    !hold_out || $stable(freq_out)) else $error("hold moved");
  a_hold_enter: assert property (ramp && $past(decel_active_out) &&
    !hold_out && freq_out != 16'h0000 &&
    bus_voltage_in > cfg_in.bus_overvoltage_threshold |=> hold_out)
    else $error("no hold");
  a_ramp_resume: assert property (hold_out && !under_voltage_in &&
    bus_voltage_in <= cfg_in.bus_overvoltage_threshold |=>
    decel_active_out && !hold_out) else $error("no resume");
  a_uv_done: assert property (decel_active_out &&
    $past(decel_active_out) && under_voltage_in |=>
    !output_enable_out && !decel_active_out) else $error("no stop");
  a_keep_going: assert property (ramp && $past(decel_active_out) &&
    freq_out != 16'h0000 |=> decel_active_out) else $error("decel quit");
  a_ramp_falls: assert property (decel_active_out &&
    $past(decel_active_out) |-> freq_out <= $past(freq_out))
    else $error("freq rose");
endmodule : power_loss_decel_chk
bind power_loss_decel power_loss_decel_chk u_chk (.ref_clk_in, .resetn_in,
  .input_power_ok_in, .under_voltage_in, .cfg_in, .bus_voltage_in,
  .freq_out, .output_enable_out, .decel_active_out, .hold_out);
`default_nettype wire

// ===== testbench/bus_model.sv
// Purpose: dc bus and mains model facing the drive
// Assumes: bus sags one count per clock without mains
// Notes: regen_in lifts the bus for over-voltage cases
`timescale 1ns/10ps
`default_nettype none
module bus_model (
  input wire logic clk_in, // control clock
  input wire logic mains_in, // mains present
  input wire logic regen_in, // regenerative surge
  output logic [13:0] bus_out, // dc bus, 0.1 V
  output logic uv_out // bus depleted
);
  logic [13:0] next_bus;
  // regen lifts the bus, else mains restores nominal, otherwise the bus sags
  always_comb begin
    // the sag stops at zero rather than wrapping to a high level
    next_bus = bus_out - 14'h0001;
    if (bus_out == 14'h0000) next_bus = bus_out;
    if (mains_in) next_bus = 14'h1900;
    if (regen_in) next_bus = bus_out + 14'h0200;
  end
  // register the bus level
  always_ff @(posedge clk_in) bus_out <= next_bus;
  assign uv_out = bus_out < 14'h1000;
endmodule : bus_model
`default_nettype wire

// ===== testbench/power_loss_decel_tb_top.sv
// Purpose: self-checking bench for power_loss_decel
// Assumes: bus model supplies dc bus and under-voltage
// Notes: ramp slope ticks are too slow to reach here
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin bad_count++; \
  $display("[FAIL] %0t got %h want %h", $time, a, e); end end
`define WAITF(c) for (n = 0; n < 5000 && !(c); n++) begin \
  @(posedge ref_clk_in); #1; end \
  if (!(c)) begin bad_count++; $display("[FAIL] %0t wait ran out", $time); end
module power_loss_decel_tb_top;
  import power_loss_decel_pkg::*;
  logic ref_clk_in, resetn_in, mains, regen, uv, oe, act, hold;
  logic [13:0] bus;
  logic [15:0] ref_f, fo, want;
  pld_cfg_t cfg;
  int bad_count, checks, n;
  logic [31:0] seed = 32'h8ab2e1e8;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction : xs
  function automatic logic [15:0] after_step(input logic [15:0] f,
    input logic [9:0] s);
    return f >= {6'h00, s} ? f - {6'h00, s} : 16'h0000;
  endfunction : after_step
  power_loss_decel u_dut (.ref_clk_in, .resetn_in, .cfg_in(cfg),
    .input_power_ok_in(mains), .bus_voltage_in(bus), .under_voltage_in(uv),
    .freq_ref_in(ref_f), .freq_out(fo), .output_enable_out(oe),
    .decel_active_out(act), .hold_out(hold));
  bus_model u_bus (.clk_in(ref_clk_in), .mains_in(mains), .regen_in(regen),
    .bus_out(bus), .uv_out(uv));
  task automatic wrap_up;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : wrap_up
  // clock and watchdog
  initial begin
    ref_clk_in = 0;
    forever #4 ref_clk_in = ~ref_clk_in;
  end
  initial begin
    // three loss cycles of about 3,100 clocks each, with ample margin
    #200us;
    bad_count++;
    wrap_up();
  end
  // power loss sequences, then the disabled case
  initial begin
    resetn_in = 0; mains = 1; regen = 0; ref_f = 16'h1388;
    cfg = '{2'h1, 14'h1700, 14'h1800, 19'h00064, 10'h064};
    repeat (8) @(posedge ref_clk_in);
    #1 `CHK({oe, act, hold, fo}, 19'h40000)
    resetn_in = 1;
    for (int i = 0; i < 3; i++) begin
      seed = xs(seed);
      ref_f = seed[15:0] | 16'h0800;
      cfg.power_loss_decel_time = {3'h0, seed[31:16]};
      cfg.initial_freq_step_drop = i == 0 ? 10'h3e8 : seed[25:16] % 10'h3e9;
      repeat (4) @(posedge ref_clk_in);
      #1 `CHK(fo, ref_f)
      mains = 0;
      repeat (5) @(posedge ref_clk_in);
      #1 `CHK(act, 1'b0)
      `WAITF(act)
      want = after_step(ref_f, cfg.initial_freq_step_drop);
      @(posedge ref_clk_in);
      #1 `CHK(fo, want)
      regen = 1;
      @(posedge ref_clk_in);
      #1 regen = 0;
      `WAITF(hold)
      `CHK(hold, 1'b1)
      `WAITF(!hold)
      `CHK(act, 1'b1)
      mains = 1;
      repeat (20) @(posedge ref_clk_in);
      #1 `CHK(act, 1'b1)
      mains = 0;
      `WAITF(!oe)
      `CHK({act, uv}, 2'b01)
      mains = 1;
      `WAITF(oe)
      `CHK({oe, act}, 2'b10)
    end
    cfg.power_loss_decel_enable = 2'h0;
    repeat (4) @(posedge ref_clk_in);
    #1 mains = 0;
    repeat (2) @(posedge ref_clk_in);
    #1 `CHK({oe, fo}, 17'h00000)
    resetn_in = 0;
    @(posedge ref_clk_in);
    #1 `CHK({oe, act, hold, fo}, 19'h40000)
    resetn_in = 1;
    @(posedge ref_clk_in);
    #1 `CHK({oe, fo}, 17'h00000)
    wrap_up();
  end
endmodule : power_loss_decel_tb_top
`default_nettype wire
